// ==== ssc_pkg.sv ====
// Constants, register map and field layout of the sync serial controller.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// Contract
// - Enable command starts receiving unless disable set
// - Transmit enable/disable commands, disable wins
// - Software reset bit 15 beats all bits
// - Enable commands leave clock settings alone
// - Divider zero stops divided clock
// - Divided clock is master over twice N
// - Receive clock source select codes 0-2
// - Clock output mode drives pin on code1
// - Invert bit picks falling or rising sample
// - Inversion never touches driven clock pin
// - Continuous start begins at enable, back-to-back
// - Frame sync level and edge start codes
// - Transmit-start, any change, any edge codes
// - Nonzero start delay waits that many clocks
// - Delay applies also after transmit start
// - Period field makes sync every 2(P+1); code makes none when P is 0
package ssc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_CMR = 8'h04;
    localparam logic [7:0] OFF_RCMR = 8'h10;
    localparam logic [7:0] OFF_RFMR = 8'h14;
    localparam logic [7:0] OFF_TCMR = 8'h18;
    localparam logic [7:0] OFF_TFMR = 8'h1c;
    localparam logic [7:0] OFF_RHR = 8'h20;
    localparam logic [7:0] OFF_THR = 8'h24;
    localparam logic [7:0] OFF_RSHR = 8'h30;
    localparam logic [7:0] OFF_TSHR = 8'h34;
    localparam logic [7:0] OFF_SR = 8'h40;
    localparam logic [7:0] OFF_IER = 8'h44;
    localparam logic [7:0] OFF_IDR = 8'h48;
    localparam logic [7:0] OFF_IMR = 8'h4c;
    // Command bits
    localparam int CMD_RX_ON = 0;
    localparam int CMD_RX_OFF = 1;
    localparam int CMD_TX_ON = 8;
    localparam int CMD_TX_OFF = 9;
    localparam int CMD_SOFT_RST = 15;
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_SR = 32'h0000_00cc;
    // Status bits owned here
    localparam int SR_RX_ON = 17;
    localparam int SR_TX_ON = 16;
    // Clock source and output codes
    localparam logic [1:0] SRC_DIV = 2'h0;
    localparam logic [1:0] SRC_TX_CLK = 2'h1;
    localparam logic [1:0] SRC_RX_PIN = 2'h2;
    localparam logic [2:0] OUT_NONE = 3'h0;
    localparam logic [2:0] OUT_CONT = 3'h1;
    // Start codes
    localparam logic [3:0] ST_CONT = 4'h0;
    localparam logic [3:0] ST_TX = 4'h1;
    localparam logic [3:0] ST_LOW = 4'h2;
    localparam logic [3:0] ST_HIGH = 4'h3;
    localparam logic [3:0] ST_FALL = 4'h4;
    localparam logic [3:0] ST_RISE = 4'h5;
    localparam logic [3:0] ST_LVL = 4'h6;
    localparam logic [3:0] ST_EDGE = 4'h7;
    // Receive clock mode register fields
    typedef struct packed {
        logic [7:0] period;
        logic [7:0] start_delay;
        logic [3:0] rsvd1;
        logic [3:0] start;
        logic [1:0] rsvd0;
        logic clock_invert;
        logic [2:0] clock_output_mode;
        logic [1:0] clock_source_select;
    } rx_clock_mode_s;
    // Wishbone request bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } ssc_wbreq_s;
endpackage

// ==== ssc_ctrl.sv ====
// Register file, commands, divider and receive clock/start timing.
// Assumes classic Wishbone master, pins synchronous to clk.
`timescale 1ns/1ps
module ssc_ctrl
#(
    parameter int DIV_W = 12
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire ssc_pkg::ssc_wbreq_s wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial pins
    input wire logic tx_clock_pin_i,
    input wire logic rx_clock_pin_i,
    output logic rx_clock_pin_o,
    output logic rx_clock_pin_oe_n,
    input wire logic rx_frame_sync_pin_i,
    input wire logic tx_start_i,
    // Status toward data path
    output logic rx_enabled_o,
    output logic tx_enabled_o,
    output logic rx_sample_o,
    output logic rx_begin_o,
    output logic rx_period_sync_o,
    input wire logic rx_word_done_i
);
    // Receive sequencer states
    typedef enum {RX_IDLE, RX_WAIT, RX_DELAY, RX_RUN} ssc_rx_e;
    // Software-visible registers
    logic [DIV_W-1:0] div_r; // Clock divider value
    ssc_pkg::rx_clock_mode_s rcmr_r; // Receive clock mode fields
    logic [31:0] rfmr_r; // Receive frame mode, stored only
    logic [31:0] tcmr_r; // Transmit clock mode, stored only
    logic [31:0] tfmr_r; // Transmit frame mode, stored only
    logic [31:0] tshr_r; // Transmit sync holding
    logic [31:0] imr_r; // Interrupt mask, set and cleared by strobes
    // Data handling enables, kept apart from clock settings
    logic rx_en_r; // Receiver handles data
    logic tx_en_r; // Transmitter handles data
    // Bus answer state
    logic ack_r; // One-cycle acknowledge
    logic [31:0] rdat_r; // Read data, held until the next read
    // Divider state
    logic [DIV_W-1:0] divcnt_r; // Master cycles into the current half period
    logic divclk_r; // Divided clock level
    // Receive clock edge tracking
    logic rclk_prev_r; // Selected clock one cycle ago
    logic rfs_prev_r; // Frame sync at the previous sampling edge
    logic rclk_out_r; // Copy of the selected clock for the pin
    // Receive start timing
    ssc_rx_e rx_st_r; // Sequencer state
    logic [7:0] dly_r; // Remaining start delay edges
    logic [8:0] per_r; // Sampling edges since the last period sync
    logic samp_r; // Sample strobe toward the data path
    logic begin_r; // Reception begins
    logic psync_r; // Period frame sync pulse
    // Bus decode
    logic acc; // Request taken this cycle
    logic wr; // Write taken this cycle
    logic soft_rst; // Software reset written this cycle
    logic rx_stop; // Receive disable or reset written this cycle
    logic [31:0] wd; // Write data
    // Receive clock decode
    logic rclk_sel; // Selected receive clock
    logic rclk_rise; // Rising edge of the selected clock
    logic rclk_fall; // Falling edge of the selected clock
    logic samp_edge; // Edge the receiver samples on
    logic fs_start; // Start condition from the selected start code

    // Merge write data by byte enable onto old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    assign acc = wb_req.cyc && wb_req.stb && !ack_r;
    assign wr = acc && wb_req.we;
    assign wd = wb_req.dat;
    // Reset command needs byte lane 1
    assign soft_rst = wr && wb_req.adr == ssc_pkg::OFF_CMD && wb_req.sel[1]
                      && wd[ssc_pkg::CMD_SOFT_RST];
    // A disable written now must also cancel a start that falls due now,
    // otherwise reception could begin in the cycle the receiver turns off
    assign rx_stop = soft_rst || (wr && wb_req.adr == ssc_pkg::OFF_CMD && wb_req.sel[0]
                     && wd[ssc_pkg::CMD_RX_OFF]);

    // Bus handshake: one wait-free ack per access
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ack_r <= 1'b0;
        else
            ack_r <= acc;
    end

    // Configuration registers
    always_ff @(posedge clk)
    begin
        if (!rst_n || soft_rst)
        begin
            div_r <= '0;
            rcmr_r <= ssc_pkg::RST_ZERO;
            rfmr_r <= ssc_pkg::RST_ZERO;
            tcmr_r <= ssc_pkg::RST_ZERO;
            tfmr_r <= ssc_pkg::RST_ZERO;
            tshr_r <= ssc_pkg::RST_ZERO;
            imr_r <= ssc_pkg::RST_ZERO;
        end
        else if (wr)
        begin
            case (wb_req.adr)
                ssc_pkg::OFF_CMR: div_r <= DIV_W'(merge(32'(div_r), wd, wb_req.sel));
                ssc_pkg::OFF_RCMR: rcmr_r <= merge(rcmr_r, wd, wb_req.sel);
                ssc_pkg::OFF_RFMR: rfmr_r <= merge(rfmr_r, wd, wb_req.sel);
                ssc_pkg::OFF_TCMR: tcmr_r <= merge(tcmr_r, wd, wb_req.sel);
                ssc_pkg::OFF_TFMR: tfmr_r <= merge(tfmr_r, wd, wb_req.sel);
                ssc_pkg::OFF_TSHR: tshr_r <= merge(tshr_r, wd, wb_req.sel);
                ssc_pkg::OFF_IER: imr_r <= imr_r | merge(32'h0, wd, wb_req.sel);
                ssc_pkg::OFF_IDR: imr_r <= imr_r & ~merge(32'h0, wd, wb_req.sel);
                default: ;
            endcase
        end
    end

    // Enable flags; only data handling changes here, clocks stay set
    always_ff @(posedge clk)
    begin
        if (!rst_n || soft_rst)
        begin
            rx_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end
        else if (wr && wb_req.adr == ssc_pkg::OFF_CMD)
        begin
            // Disable wins over enable written in the same command
            if (wb_req.sel[0] && wd[ssc_pkg::CMD_RX_OFF])
                rx_en_r <= 1'b0;
            else if (wb_req.sel[0] && wd[ssc_pkg::CMD_RX_ON])
                rx_en_r <= 1'b1;
            if (wb_req.sel[1] && wd[ssc_pkg::CMD_TX_OFF])
                tx_en_r <= 1'b0;
            else if (wb_req.sel[1] && wd[ssc_pkg::CMD_TX_ON])
                tx_en_r <= 1'b1;
        end
    end

    // Read mux; unmapped and write-only offsets read zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdat_r <= ssc_pkg::RST_ZERO;
        else if (acc && !wb_req.we)
        begin
            case (wb_req.adr)
                ssc_pkg::OFF_CMR: rdat_r <= 32'(div_r);
                ssc_pkg::OFF_RCMR: rdat_r <= rcmr_r;
                ssc_pkg::OFF_RFMR: rdat_r <= rfmr_r;
                ssc_pkg::OFF_TCMR: rdat_r <= tcmr_r;
                ssc_pkg::OFF_TFMR: rdat_r <= tfmr_r;
                ssc_pkg::OFF_TSHR: rdat_r <= tshr_r;
                ssc_pkg::OFF_IMR: rdat_r <= imr_r;
                ssc_pkg::OFF_SR: rdat_r <= ssc_pkg::RST_SR
                    | (32'(rx_en_r) << ssc_pkg::SR_RX_ON)
                    | (32'(tx_en_r) << ssc_pkg::SR_TX_ON);
                default: rdat_r <= ssc_pkg::RST_ZERO;
            endcase
        end
    end

    // Divided clock: toggles every N master cycles, so period is 2N
    always_ff @(posedge clk)
    begin
        if (!rst_n || div_r == '0)
        begin
            divcnt_r <= '0;
            divclk_r <= 1'b0;
        end
        else if (divcnt_r >= div_r - DIV_W'(1))
        begin
            divcnt_r <= '0;
            divclk_r <= ~divclk_r;
        end
        else
            divcnt_r <= divcnt_r + DIV_W'(1);
    end

    // Receive clock source select
    always_comb
    begin
        case (rcmr_r.clock_source_select)
            ssc_pkg::SRC_DIV: rclk_sel = divclk_r;
            ssc_pkg::SRC_TX_CLK: rclk_sel = tx_clock_pin_i;
            ssc_pkg::SRC_RX_PIN: rclk_sel = rx_clock_pin_i;
            default: rclk_sel = 1'b0;
        endcase
    end

    assign rclk_rise = rclk_sel && !rclk_prev_r;
    assign rclk_fall = !rclk_sel && rclk_prev_r;
    // Sampling edge from inversion bit
    assign samp_edge = rcmr_r.clock_invert ? rclk_rise : rclk_fall;

    // Start event decode on the sampling edge
    always_comb
    begin
        case (rcmr_r.start)
            ssc_pkg::ST_CONT: fs_start = 1'b1;
            ssc_pkg::ST_TX: fs_start = tx_start_i;
            ssc_pkg::ST_LOW: fs_start = !rx_frame_sync_pin_i;
            ssc_pkg::ST_HIGH: fs_start = rx_frame_sync_pin_i;
            ssc_pkg::ST_FALL: fs_start = rfs_prev_r && !rx_frame_sync_pin_i;
            ssc_pkg::ST_RISE: fs_start = !rfs_prev_r && rx_frame_sync_pin_i;
            ssc_pkg::ST_LVL: fs_start = rfs_prev_r != rx_frame_sync_pin_i;
            ssc_pkg::ST_EDGE: fs_start = rfs_prev_r != rx_frame_sync_pin_i;
            default: fs_start = 1'b0;
        endcase
    end

    // Edge history of clock and frame sync
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rclk_prev_r <= 1'b0;
            rfs_prev_r <= 1'b0;
        end
        else
        begin
            rclk_prev_r <= rclk_sel;
            if (samp_edge)
                rfs_prev_r <= rx_frame_sync_pin_i;
        end
    end

    // Receive clock output pin, never inverted
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rclk_out_r <= 1'b0;
            rx_clock_pin_oe_n <= 1'b1;
        end
        else
        begin
            rclk_out_r <= rclk_sel;
            rx_clock_pin_oe_n <= rcmr_r.clock_output_mode != ssc_pkg::OUT_CONT;
        end
    end

    // Receive start sequencer with start delay
    always_ff @(posedge clk)
    begin
        if (!rst_n || rx_stop || !rx_en_r)
        begin
            rx_st_r <= RX_IDLE;
            dly_r <= '0;
            begin_r <= 1'b0;
        end
        else
        begin
            begin_r <= 1'b0;
            case (rx_st_r)
                RX_IDLE: rx_st_r <= RX_WAIT;
                RX_WAIT:
                    if (samp_edge && fs_start)
                    begin
                        if (rcmr_r.start_delay == '0)
                        begin
                            rx_st_r <= RX_RUN;
                            begin_r <= 1'b1;
                        end
                        else
                        begin
                            dly_r <= rcmr_r.start_delay;
                            rx_st_r <= RX_DELAY;
                        end
                    end
                RX_DELAY:
                    if (samp_edge)
                    begin
                        if (dly_r == 8'h01)
                        begin
                            rx_st_r <= RX_RUN;
                            begin_r <= 1'b1;
                        end
                        dly_r <= dly_r - 8'h01;
                    end
                RX_RUN:
                    if (rx_word_done_i)
                        rx_st_r <= RX_WAIT;
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // Period frame sync: one pulse each 2(P+1) receive clocks, no pulse while P is 0
    always_ff @(posedge clk)
    begin
        if (!rst_n || rcmr_r.period == '0)
        begin
            per_r <= '0;
            psync_r <= 1'b0;
        end
        else
        begin
            psync_r <= 1'b0;
            if (samp_edge)
            begin
                if (per_r >= {rcmr_r.period, 1'b1})
                begin
                    per_r <= '0;
                    psync_r <= 1'b1;
                end
                else
                    per_r <= per_r + 9'h001;
            end
        end
    end

    // Sample strobe for the data path
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            samp_r <= 1'b0;
        else
            samp_r <= samp_edge && rx_st_r == RX_RUN && rx_en_r;
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign rx_clock_pin_o = rclk_out_r;
    assign rx_enabled_o = rx_en_r;
    assign tx_enabled_o = tx_en_r;
    assign rx_sample_o = samp_r;
    assign rx_begin_o = begin_r;
    assign rx_period_sync_o = psync_r;
endmodule

// ==== ssc_ctrl_properties.sv ====
// Port-level timing checks for the serial controller's control block.
// Assumes one clock domain and the single-cycle bus answer.
`timescale 1ns/1ps
module ssc_ctrl_properties
#(
    parameter int DIV_W = 12
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus
    input wire ssc_pkg::ssc_wbreq_s wb_req,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Serial pins and status
    input wire logic tx_clock_pin_i,
    input wire logic rx_clock_pin_i,
    input wire logic rx_clock_pin_o,
    input wire logic rx_clock_pin_oe_n,
    input wire logic rx_frame_sync_pin_i,
    input wire logic tx_start_i,
    input wire logic rx_enabled_o,
    input wire logic tx_enabled_o,
    input wire logic rx_sample_o,
    input wire logic rx_begin_o,
    input wire logic rx_period_sync_o,
    input wire logic rx_word_done_i
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Command write taken at this edge
    sequence s_cmd;
        wb_req.cyc && wb_req.stb && wb_req.we && !wb_ack_o && wb_req.adr == ssc_pkg::OFF_CMD;
    endsequence
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ack_due;
        wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o;
    endproperty
    property p_rx_on;
        $rose(rx_enabled_o) && $past(rst_n) |-> wb_ack_o;
    endproperty
    property p_tx_on;
        $rose(tx_enabled_o) && $past(rst_n) |-> wb_ack_o;
    endproperty
    property p_rx_en;
        s_cmd ##0 (wb_req.sel[0] && wb_req.dat[0] && !wb_req.dat[1] && !wb_req.dat[15])
            |=> rx_enabled_o;
    endproperty
    property p_rx_off;
        s_cmd ##0 (wb_req.sel[0] && wb_req.dat[1]) |=> !rx_enabled_o;
    endproperty
    property p_tx_off;
        s_cmd ##0 (wb_req.sel[1] && wb_req.dat[9]) |=> !tx_enabled_o;
    endproperty
    property p_soft_rst;
        s_cmd ##0 (wb_req.sel[1] && wb_req.dat[15]) |=> !rx_enabled_o && !tx_enabled_o;
    endproperty
    property p_begin_en;
        rx_begin_o |-> rx_enabled_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    a_ack_due: assert property (p_ack_due) else $error("request not answered next cycle");
    a_rx_on: assert property (p_rx_on) else $error("receiver enabled without a write");
    a_tx_on: assert property (p_tx_on) else $error("transmitter enabled without a write");
    a_rx_en: assert property (p_rx_en) else $error("receive enable ignored");
    a_rx_off: assert property (p_rx_off) else $error("receive disable ignored");
    a_tx_off: assert property (p_tx_off) else $error("transmit disable ignored");
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset left a path on");
    a_begin_en: assert property (p_begin_en) else $error("reception began while off");
endmodule
bind ssc_ctrl ssc_ctrl_properties #(.DIV_W(DIV_W)) ssc_ctrl_properties_inst (.clk(clk),
    .rst_n(rst_n), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_clock_pin_i(tx_clock_pin_i), .rx_clock_pin_i(rx_clock_pin_i),
    .rx_clock_pin_o(rx_clock_pin_o), .rx_clock_pin_oe_n(rx_clock_pin_oe_n),
    .rx_frame_sync_pin_i(rx_frame_sync_pin_i), .tx_start_i(tx_start_i),
    .rx_enabled_o(rx_enabled_o), .tx_enabled_o(tx_enabled_o), .rx_sample_o(rx_sample_o),
    .rx_begin_o(rx_begin_o), .rx_period_sync_o(rx_period_sync_o),
    .rx_word_done_i(rx_word_done_i));

// ==== ssc_codec_model.sv ====
// Serial peer: supplies both clock pins and the frame sync level.
// Assumes the controller clock; peer clock runs only while run is high.
`timescale 1ns/1ps
module ssc_codec_model
#(
    parameter int HALF = 3
)
(
    // Clock and bench control
    input wire logic clk,
    input wire logic run,
    input wire logic fs_req,
    // Controller side of the shared clock pin
    input wire logic rx_clk_drv,
    input wire logic rx_clk_drv_oe_n,
    // Pin levels seen by the controller
    output logic tx_clk_pin,
    output logic rx_clk_pin,
    output logic fs
);
    int cnt;
    logic pclk;
    // Peer clock toggles every HALF cycles, still outside frames
    always_ff @(posedge clk)
    begin
        if (!run)
        begin
            cnt <= 0;
            pclk <= 1'b0;
        end
        else if (cnt == HALF - 1)
        begin
            cnt <= 0;
            pclk <= ~pclk;
        end
        else
        begin
            cnt <= cnt + 1;
        end
    end
    assign tx_clk_pin = run & pclk;
    // Controller wins the shared pin while it drives
    assign rx_clk_pin = rx_clk_drv_oe_n ? (run & pclk) : rx_clk_drv;
    assign fs = fs_req;
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the control block over the register bus.
// Assumes the peer model supplies clocks with a half period of 3 cycles.
`timescale 1ns/1ps
module tb_top;
    localparam int DIVN = 2;
    localparam int HALF = 3;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ssc_pkg::ssc_wbreq_s wb_req = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, tx_clk, rx_clk, fs, rx_clk_o, rx_clk_oe_n, rx_en, tx_en, smp, beg, psync;
    logic tx_start = 1'b0;
    logic word_done = 1'b0;
    logic run = 1'b0;
    logic fs_req = 1'b0;
    int err_count = 0;
    int checks_done = 0;
    logic [31:0] q;
    int n, s;
    always #2.5 clk = ~clk;
    ssc_ctrl #(.DIV_W(12)) ssc_ctrl_inst (.clk(clk), .rst_n(rst_n), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_clock_pin_i(tx_clk),
        .rx_clock_pin_i(rx_clk), .rx_clock_pin_o(rx_clk_o), .rx_clock_pin_oe_n(rx_clk_oe_n),
        .rx_frame_sync_pin_i(fs),
        .tx_start_i(tx_start), .rx_enabled_o(rx_en), .tx_enabled_o(tx_en),
        .rx_sample_o(smp), .rx_begin_o(beg), .rx_period_sync_o(psync),
        .rx_word_done_i(word_done));
    ssc_codec_model #(.HALF(HALF)) ssc_codec_model_inst (.clk(clk), .run(run),
        .fs_req(fs_req), .rx_clk_drv(rx_clk_o), .rx_clk_drv_oe_n(rx_clk_oe_n),
        .tx_clk_pin(tx_clk), .rx_clk_pin(rx_clk), .fs(fs));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic bus cycle, held until ack is sampled
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        wb_req <= '{1'b1, 1'b1, w, 4'hf, a, d};
        do
            @(posedge clk);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_req <= '0;
        @(posedge clk);
    endtask
    // Wait for begin (0), period sync (1) or sample (2), counting samples
    task automatic wait_sig(input int k, input int lim);
        logic x;
        n = 0;
        s = 0;
        do
        begin
            @(posedge clk);
            n++;
            s += int'(smp === 1'b1);
            x = (k == 0) ? beg : (k == 1) ? psync : smp;
        end
        while (x !== 1'b1 && n < lim);
    endtask
    // Every readable place at its reset value, unmapped and write-only at 0
    task automatic reset_reads();
        logic [7:0] offs [11] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h30, 8'h34,
            8'h4c, 8'h00, 8'h50};
        foreach (offs[i])
        begin
            bus(offs[i], 1'b0, 32'h0);
            chk(q, 32'h0);
        end
        bus(ssc_pkg::OFF_SR, 1'b0, 32'h0);
        chk(q, ssc_pkg::RST_SR);
    endtask
    task automatic results();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge clk);
        err_count++;
        results();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        reset_reads();
        bus(ssc_pkg::OFF_TSHR, 1'b1, 32'h5a);
        bus(ssc_pkg::OFF_RCMR, 1'b1, 32'h0102_0325);
        bus(ssc_pkg::OFF_CMD, 1'b1, 32'h3);
        chk(rx_en, 1'b0);
        bus(ssc_pkg::OFF_CMD, 1'b1, 32'h1);
        chk(rx_en, 1'b1);
        bus(ssc_pkg::OFF_CMD, 1'b1, 32'h300);
        chk(tx_en, 1'b0);
        bus(ssc_pkg::OFF_CMD, 1'b1, 32'h100);
        chk(tx_en, 1'b1);
        bus(ssc_pkg::OFF_SR, 1'b0, 32'h0);
        chk(q, 32'h0003_00cc);
        bus(ssc_pkg::OFF_CMD, 1'b1, 32'h2);
        chk(rx_en, 1'b0);
        bus(ssc_pkg::OFF_RCMR, 1'b0, 32'h0);
        chk(q, 32'h0102_0325);
        bus(ssc_pkg::OFF_CMD, 1'b1, 32'h8101);
        chk({rx_en, tx_en}, 2'b00);
        reset_reads();
        run <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            bus(ssc_pkg::OFF_CMD, 1'b1, 32'h8000);
            bus(ssc_pkg::OFF_CMR, 1'b1, 32'(DIVN));
            bus(ssc_pkg::OFF_RCMR, 1'b1, (k == 0) ? 32'h4 : 32'(k));
            bus(ssc_pkg::OFF_CMD, 1'b1, 32'h1);
            chk(rx_clk_oe_n, k != 0);
            wait_sig(2, 200);
            wait_sig(2, 200);
            chk(n, (k == 0) ? 2 * DIVN : 2 * HALF);
        end
        run <= 1'b0;
        bus(ssc_pkg::OFF_CMD, 1'b1, 32'h8000);
        bus(ssc_pkg::OFF_CMD, 1'b1, 32'h1);
        wait_sig(2, 40);
        chk(n, 40);
        bus(ssc_pkg::OFF_CMR, 1'b1, 32'(DIVN));
        bus(ssc_pkg::OFF_RCMR, 1'b1, 32'h0102_0004);
        wait_sig(0, 200);
        chk(beg, 1'b1);
        word_done <= 1'b1;
        @(posedge clk);
        word_done <= 1'b0;
        wait_sig(0, 200);
        // Start at the next sampling edge, then two receive clocks of delay
        chk(s, 0);
        chk(n >= 4 * DIVN + 2 && n <= 6 * DIVN + 1, 1'b1);
        wait_sig(1, 200);
        wait_sig(1, 200);
        chk(s, 4);
        // Falling-edge sampling: the driven clock is low at the sample
        wait_sig(2, 200);
        chk(rx_clk_o, 1'b0);
        for (int c = 1; c < 8; c++)
        begin
            bus(ssc_pkg::OFF_CMD, 1'b1, 32'h8000);
            fs_req <= ~c[0];
            tx_start <= 1'b0;
            bus(ssc_pkg::OFF_CMR, 1'b1, 32'h1);
            bus(ssc_pkg::OFF_RCMR, 1'b1, 32'(c) << 8);
            bus(ssc_pkg::OFF_CMD, 1'b1, 32'h1);
            wait_sig(0, 20);
            chk(n, 20);
            fs_req <= c[0];
            tx_start <= 1'b1;
            wait_sig(0, 40);
            chk(n < 40, 1'b1);
        end
        // Shared start with delay, sampling on the rising edge
        bus(ssc_pkg::OFF_CMD, 1'b1, 32'h8000);
        tx_start <= 1'b0;
        bus(ssc_pkg::OFF_CMR, 1'b1, 32'(DIVN));
        bus(ssc_pkg::OFF_RCMR, 1'b1, 32'h0002_0124);
        bus(ssc_pkg::OFF_CMD, 1'b1, 32'h1);
        tx_start <= 1'b1;
        wait_sig(0, 40);
        chk(n >= 4 * DIVN + 2 && n <= 6 * DIVN + 1, 1'b1);
        wait_sig(2, 200);
        chk(rx_clk_o, 1'b1);
        results();
    end
endmodule
